// File: pvsc_ctrl.sv
// profile velocity sub-mode control: command word decode, ramp, alarms
// Operation
// [R1] sub-mode comes from command bits 13:12 and applies at once
// [R2] command bit 8 set stops motion by the chosen stop method; sub-mode 11 always stops at once, whatever the stop method
// [R3] sub-modes 00, 01, 10 launch at launch speed then ramp and hold
// [R4] sub-mode 00 raises overload or deviation alarm under excess load
// [R5] sub-mode 00 corrects sudden deviation, possibly accelerating sharply
// [R6] sub-mode 01 raises only overload, never a deviation alarm
// [R7] sub-mode 10 presses on the load without alarming
// [R8] sub-mode 11 steps straight to commanded speed and presses on
// [R9] master backs off 3.6 degrees before stopping a press; pvsc_master has no back-off, the bench only drops load_over_torque and pos_dev
// [R10] master keeps next drive current at or below press limit; the project models no drive current or press limit
`timescale 1ns/100ps
module pvsc_ctrl
#(
	parameter pvsc_pkg::pvsc_speed_t RAMP_STEP = pvsc_pkg::RAMP_STEP_DEF,
	parameter pvsc_pkg::pvsc_speed_t DEV_LIMIT = pvsc_pkg::DEV_LIMIT_DEF,
	parameter int OVL_CYCLES = pvsc_pkg::OVL_CYCLES_DEF,
	parameter int CORR_SHIFT = pvsc_pkg::CORR_SHIFT_DEF
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// command object access
	input wire pvsc_pkg::pvsc_cmd_s cmd,
	output logic [15:0] cmd_rdata_r,
	output logic cmd_rack_r,
	// motion settings
	input wire pvsc_pkg::pvsc_speed_t commanded_speed,
	input wire pvsc_pkg::pvsc_speed_t launch_speed,
	input wire logic [15:0] stop_method_code,
	// motor feedback
	input wire pvsc_pkg::pvsc_speed_t pos_dev,
	input wire logic load_over_torque,
	input wire logic alarm_clr,
	// motion outputs
	output pvsc_pkg::pvsc_speed_t speed_cmd_r,
	output logic [15:0] cmd_word_r,
	output pvsc_pkg::pvsc_status_s status_r
);

	typedef struct packed {
		logic [15:0] cmd_word;
		logic [15:0] rdata;
		logic rack;
		pvsc_pkg::pvsc_speed_t speed_cmd;
		logic [31:0] ovl_cnt;
		pvsc_pkg::pvsc_run_e run;
		pvsc_pkg::pvsc_status_s st;
	} pvsc_ctrl_s;

	pvsc_ctrl_s r;
	pvsc_ctrl_s n;

	logic wr_hit;
	logic [1:0] sub_mode;
	logic halt;
	logic stopping;
	logic bypass;
	logic running;
	logic dev_big;
	pvsc_pkg::pvsc_speed_t ramp_tgt;
	pvsc_pkg::pvsc_speed_t ramp_speed;
	pvsc_pkg::pvsc_speed_t abs_dev;

	function automatic logic is_press(input logic [1:0] m);
		is_press = (m == pvsc_pkg::SM_PUSH) || (m == pvsc_pkg::SM_TORQ);
	endfunction

	// ==========================================
	// decode
	assign wr_hit = cmd.wr && (cmd.index == pvsc_pkg::CMD_INDEX);
	assign sub_mode = r.cmd_word[pvsc_pkg::SUBMODE_MSB:pvsc_pkg::SUBMODE_LSB]; // [R1]
	assign halt = r.cmd_word[pvsc_pkg::HALT_BIT]; // [R2]
	assign stopping = halt || r.st.ovl_alarm || r.st.dev_alarm;
	assign ramp_tgt = stopping ? '0 : commanded_speed; // [R2]
	// torque mode has no ramps at all; other stops follow the stop method
	assign bypass = (sub_mode == pvsc_pkg::SM_TORQ) ||
		(stopping && stop_method_code != pvsc_pkg::STOP_DECEL); // [R2] [R8]
	assign running = (ramp_speed != 0);
	assign abs_dev = (pos_dev < 0) ? -pos_dev : pos_dev;
	assign dev_big = abs_dev > DEV_LIMIT;

	pvsc_ramp u_ramp
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.target(ramp_tgt),
		.floor_mag(launch_speed), // [R3]
		.step(RAMP_STEP),
		.bypass(bypass),
		.speed(ramp_speed)
	);

	// ==========================================
	// next state
	always_comb
	begin
		n = r;
		n.rack = cmd.rd;
		n.rdata = (cmd.rd && cmd.index == pvsc_pkg::CMD_INDEX) ? r.cmd_word : '0;
		if (wr_hit)
			n.cmd_word = cmd.wdata; // [R1]
		// load beyond torque: counted only where an overload is an alarm
		if (running && load_over_torque && !is_press(sub_mode))
			n.ovl_cnt = (r.ovl_cnt >= 32'(OVL_CYCLES - 1)) ? r.ovl_cnt : r.ovl_cnt + 32'h0000_0001;
		else
			n.ovl_cnt = '0;
		if (alarm_clr)
		begin
			n.st.ovl_alarm = 1'b0;
			n.st.dev_alarm = 1'b0;
		end
		// set wins over a clear in the same cycle
		if (r.ovl_cnt >= 32'(OVL_CYCLES - 1))
			n.st.ovl_alarm = 1'b1; // [R4] [R6]
		if (running && dev_big && sub_mode == pvsc_pkg::SM_POS)
			n.st.dev_alarm = 1'b1; // [R4]
		n.st.pressing = running && load_over_torque && is_press(sub_mode); // [R7] [R8]
		// deviation feeds forward so lost steps are made up, at a speed spike
		if (sub_mode == pvsc_pkg::SM_POS && running && !stopping)
			n.speed_cmd = ramp_speed + (pos_dev >>> CORR_SHIFT); // [R5]
		else
			n.speed_cmd = ramp_speed;
		if (!running)
			n.run = pvsc_pkg::RS_IDLE;
		else if (stopping)
			n.run = pvsc_pkg::RS_HALT;
		else if (ramp_speed == commanded_speed)
			n.run = pvsc_pkg::RS_HOLD; // [R3]
		else
			n.run = pvsc_pkg::RS_RAMP;
		n.st.at_speed = (n.run == pvsc_pkg::RS_HOLD);
		n.st.speed_zero = !running;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.cmd_word <= pvsc_pkg::CMD_RESET;
			r.run <= pvsc_pkg::RS_IDLE;
			r.st.speed_zero <= 1'b1;
		end
		else
			r <= n;
	end

	assign cmd_word_r = r.cmd_word;
	assign cmd_rdata_r = r.rdata;
	assign cmd_rack_r = r.rack;
	assign speed_cmd_r = r.speed_cmd;
	assign status_r = r.st;

	// ==========================================
	// checks
	property p_submode_now;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_hit |=> (sub_mode == $past(cmd.wdata[13:12]));
	endproperty
	a_submode_now: assert property (p_submode_now) else $error("sub-mode not taken"); // [R1]

	property p_halt_stop;
		@(posedge clk_sys) disable iff (!rst_n)
		(halt && stop_method_code != pvsc_pkg::STOP_DECEL) [*2] |-> (ramp_speed == 0);
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop"); // [R2]

	property p_launch;
		@(posedge clk_sys) disable iff (!rst_n)
		(!running && !stopping && sub_mode != pvsc_pkg::SM_TORQ && launch_speed > 0
			&& commanded_speed > launch_speed) |=> (ramp_speed == $past(launch_speed));
	endproperty
	a_launch: assert property (p_launch) else $error("launch speed wrong"); // [R3]

	property p_pos_dev_alarm;
		@(posedge clk_sys) disable iff (!rst_n)
		(running && dev_big && sub_mode == pvsc_pkg::SM_POS) |=> r.st.dev_alarm;
	endproperty
	a_pos_dev_alarm: assert property (p_pos_dev_alarm) else $error("no deviation alarm"); // [R4]

	property p_correct;
		@(posedge clk_sys) disable iff (!rst_n)
		(sub_mode == pvsc_pkg::SM_POS && running && !stopping && (pos_dev >>> CORR_SHIFT) > 0)
			|=> (speed_cmd_r > $past(ramp_speed));
	endproperty
	a_correct: assert property (p_correct) else $error("deviation not corrected"); // [R5]

	property p_spd_no_dev;
		@(posedge clk_sys) disable iff (!rst_n)
		(sub_mode == pvsc_pkg::SM_SPD && !r.st.dev_alarm) |=> !r.st.dev_alarm;
	endproperty
	a_spd_no_dev: assert property (p_spd_no_dev) else $error("deviation alarm in speed mode"); // [R6]

	property p_push_quiet;
		@(posedge clk_sys) disable iff (!rst_n)
		(sub_mode == pvsc_pkg::SM_PUSH && !r.st.ovl_alarm && !r.st.dev_alarm)
			|=> (!r.st.ovl_alarm && !r.st.dev_alarm);
	endproperty
	a_push_quiet: assert property (p_push_quiet) else $error("alarm while pressing"); // [R7]

	property p_torq_step;
		@(posedge clk_sys) disable iff (!rst_n)
		(sub_mode == pvsc_pkg::SM_TORQ && !stopping) |=> (ramp_speed == $past(commanded_speed));
	endproperty
	a_torq_step: assert property (p_torq_step) else $error("torque mode ramped"); // [R8]

	property p_ovl_set;
		@(posedge clk_sys) disable iff (!rst_n)
		(r.ovl_cnt >= 32'(OVL_CYCLES - 1)) |=> status_r.ovl_alarm;
	endproperty
	a_ovl_set: assert property (p_ovl_set) else $error("no overload alarm"); // [R6]

	property p_press_flag;
		@(posedge clk_sys) disable iff (!rst_n)
		(running && load_over_torque && is_press(sub_mode)) |=> status_r.pressing;
	endproperty
	a_press_flag: assert property (p_press_flag) else $error("pressing not shown"); // [R8]

	property p_at_speed;
		@(posedge clk_sys) disable iff (!rst_n)
		(running && !stopping && ramp_speed == commanded_speed) |=> status_r.at_speed;
	endproperty
	a_at_speed: assert property (p_at_speed) else $error("hold not shown"); // [R3]

endmodule

// File: pvsc_pkg.sv
// constants and carriers for the profile velocity sub-mode control block
package pvsc_pkg;

	// ==========================================
	// command object
	localparam logic [15:0] CMD_INDEX = 16'h6040;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam int HALT_BIT = 8;
	localparam int SUBMODE_LSB = 12;
	localparam int SUBMODE_MSB = 13;

	// ==========================================
	// sub-mode encodings
	localparam logic [1:0] SM_POS = 2'h0;
	localparam logic [1:0] SM_SPD = 2'h1;
	localparam logic [1:0] SM_PUSH = 2'h2;
	localparam logic [1:0] SM_TORQ = 2'h3;

	// ==========================================
	// stop method codes
	localparam logic [15:0] STOP_DECEL = 16'h0001;

	// ==========================================
	// tuning defaults
	localparam logic [31:0] RAMP_STEP_DEF = 32'h0000_0010;
	localparam logic [31:0] DEV_LIMIT_DEF = 32'h0000_0200;
	localparam int OVL_CYCLES_DEF = 1000;
	localparam int CORR_SHIFT_DEF = 2;

	typedef logic signed [31:0] pvsc_speed_t;

	// ==========================================
	// carriers
	typedef struct packed {
		logic ovl_alarm;
		logic dev_alarm;
		logic pressing;
		logic at_speed;
		logic speed_zero;
	} pvsc_status_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] index;
		logic [15:0] wdata;
	} pvsc_cmd_s;

	typedef enum logic [1:0] {
		RS_IDLE,
		RS_RAMP,
		RS_HOLD,
		RS_HALT
	} pvsc_run_e;

endpackage

// File: pvsc_ramp.sv
// speed ramp generator with launch speed and direct step
`timescale 1ns/100ps
module pvsc_ramp
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire pvsc_pkg::pvsc_speed_t target,
	input wire pvsc_pkg::pvsc_speed_t floor_mag,
	input wire pvsc_pkg::pvsc_speed_t step,
	input wire logic bypass,
	// result
	output pvsc_pkg::pvsc_speed_t speed
);

	typedef struct packed {
		pvsc_pkg::pvsc_speed_t cur;
	} pvsc_ramp_s;

	pvsc_ramp_s r;
	pvsc_ramp_s n;
	pvsc_pkg::pvsc_speed_t abs_cur;
	pvsc_pkg::pvsc_speed_t abs_tgt;
	pvsc_pkg::pvsc_speed_t mag;

	always_comb
	begin
		n = r;
		abs_cur = (r.cur < 0) ? -r.cur : r.cur;
		abs_tgt = (target < 0) ? -target : target;
		mag = (abs_tgt < floor_mag) ? abs_tgt : floor_mag;
		if (bypass)
			n.cur = target;
		else if (r.cur == 0 && target != 0)
			n.cur = (target < 0) ? -mag : mag;
		// a stepper can drop out from below its launch speed
		else if (target == 0 && abs_cur <= floor_mag)
			n.cur = '0;
		else if (r.cur < target)
			n.cur = (target - r.cur > step) ? r.cur + step : target;
		else if (r.cur > target)
			n.cur = (r.cur - target > step) ? r.cur - step : target;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	assign speed = r.cur;

endmodule

// File: pvsc_master.sv
// fieldbus master model issuing command object accesses
`timescale 1ns/100ps
module pvsc_master
(
	// clock
	input wire logic clk_sys,
	// command object
	output pvsc_pkg::pvsc_cmd_s cmd,
	input wire logic [15:0] cmd_rdata_r,
	input wire logic cmd_rack_r
);
	initial cmd = '0;
	// one-cycle request; released fields are inverted so stale values never match
	task automatic acc(input logic w, input logic [15:0] idx, d, output logic [15:0] q);
		@(negedge clk_sys);
		cmd <= '{wr: w, rd: !w, index: idx, wdata: d};
		@(negedge clk_sys);
		q = cmd_rack_r ? cmd_rdata_r : 16'hxxxx;
		cmd <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~d};
	endtask
endmodule

// File: pvsc_ctrl_tb.sv
// self-checking bench for the profile velocity sub-mode control
`timescale 1ns/100ps
module pvsc_ctrl_tb;
	localparam pvsc_pkg::pvsc_speed_t STEP = pvsc_pkg::RAMP_STEP_DEF;
	logic clk_sys, rst_n, load_over_torque, alarm_clr, cmd_rack_r;
	logic [15:0] cmd_rdata_r, stop_method_code, cmd_word_r, q;
	pvsc_pkg::pvsc_cmd_s cmd;
	pvsc_pkg::pvsc_speed_t commanded_speed, launch_speed, pos_dev, speed_cmd_r, e;
	pvsc_pkg::pvsc_status_s status_r;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	integer seed;

	// ==========================================
	// design and partner
	pvsc_ctrl #(.OVL_CYCLES(4)) i_pvsc_ctrl (.clk_sys, .rst_n, .cmd, .cmd_rdata_r,
		.cmd_rack_r, .commanded_speed, .launch_speed, .stop_method_code, .pos_dev,
		.load_over_torque, .alarm_clr, .speed_cmd_r, .cmd_word_r, .status_r);
	pvsc_master i_pvsc_master (.clk_sys, .cmd, .cmd_rdata_r, .cmd_rack_r);

	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			fails++;
			stop_test();
		end
	end

	// ==========================================
	// helpers
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_val(input string name, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_bit(input string name, input logic exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic cycles(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task automatic go(input logic [15:0] w);
		i_pvsc_master.acc(1'b1, 16'h6040, w, q);
	endtask
	// bounded wait: for v, or for any other value when leave is set
	task automatic wait_for(input pvsc_pkg::pvsc_speed_t v, input logic leave, input int lim);
		n = 0;
		while (((speed_cmd_r === v) === leave) && n < lim)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic clr_alarms();
		load_over_torque = 1'b0;
		pos_dev = '0;
		alarm_clr = 1'b1;
		cycles(1);
		alarm_clr = 1'b0;
	endtask
	function automatic pvsc_pkg::pvsc_speed_t ramp_exp(input pvsc_pkg::pvsc_speed_t cur);
		if (cur == 0)
			return (commanded_speed < launch_speed) ? commanded_speed : launch_speed;
		return (cur + STEP > commanded_speed) ? commanded_speed : cur + STEP;
	endfunction

	// ==========================================
	// tests
	initial
	begin
		seed = 32'h5770;
		rst_n = 1'b0;
		load_over_torque = 1'b0;
		alarm_clr = 1'b0;
		pos_dev = '0;
		stop_method_code = pvsc_pkg::STOP_DECEL;
		launch_speed = 32'sd100;
		// idle until a mode is written: word 0 means mode 00, not halted
		commanded_speed = '0;
		cycles(20);
		chk_val("reset word", pvsc_pkg::CMD_RESET, cmd_word_r);
		rst_n = 1'b1;
		i_pvsc_master.acc(1'b1, 16'h6041, 16'hffff, q);
		i_pvsc_master.acc(1'b0, 16'h6040, 16'h0000, q);
		chk_val("word read", pvsc_pkg::CMD_RESET, q);
		i_pvsc_master.acc(1'b0, 16'h6041, 16'h0000, q);
		chk_val("unmapped read", 16'h0000, q);
		$display("test registers done");
		go(16'h1000);
		chk_val("word write", 16'h1000, cmd_word_r);
		commanded_speed = 32'sd140 + ($random(seed) & 32'h3f);
		wait_for('0, 1'b1, 8);
		chk_bit("mode latency", 1'b1, n <= 3);
		e = '0;
		do
		begin
			e = ramp_exp(e);
			chk_val("ramp speed", e, speed_cmd_r);
			@(negedge clk_sys);
		end
		while (e != commanded_speed);
		chk_bit("at speed", 1'b1, status_r.at_speed);
		$display("test ramp done");
		go(16'h1100);
		wait_for(commanded_speed, 1'b1, 8);
		chk_val("decel step", commanded_speed - STEP, speed_cmd_r);
		wait_for('0, 1'b0, 20);
		chk_val("decel stop", 32'h0, speed_cmd_r);
		go(16'h3000);
		wait_for('0, 1'b1, 8);
		chk_val("direct step", commanded_speed, speed_cmd_r);
		stop_method_code = 16'h0000;
		go(16'h1100);
		cycles(3);
		chk_val("abrupt stop", 32'h0, speed_cmd_r);
		chk_bit("speed zero", 1'b1, status_r.speed_zero);
		$display("test halt done");
		go(16'h1000);
		wait_for(commanded_speed, 1'b0, 40);
		load_over_torque = 1'b1;
		pos_dev = 32'sh400;
		cycles(8);
		chk_bit("overload", 1'b1, status_r.ovl_alarm);
		chk_bit("no deviation", 1'b0, status_r.dev_alarm);
		clr_alarms();
		cycles(1);
		chk_bit("cleared", 1'b0, status_r.ovl_alarm);
		go(16'h0000);
		wait_for(commanded_speed, 1'b0, 40);
		pos_dev = 32'sh40;
		cycles(3);
		chk_val("correction", commanded_speed + 32'sh10, speed_cmd_r);
		pos_dev = 32'sh201 + ($random(seed) & 32'hff);
		cycles(3);
		chk_bit("deviation", 1'b1, status_r.dev_alarm);
		clr_alarms();
		go(16'h2000);
		wait_for(commanded_speed, 1'b0, 40);
		load_over_torque = 1'b1;
		pos_dev = 32'sh400;
		cycles(8);
		chk_bit("pressing", 1'b1, status_r.pressing);
		chk_bit("press overload", 1'b0, status_r.ovl_alarm);
		chk_bit("press deviation", 1'b0, status_r.dev_alarm);
		// back off the press before halting it
		load_over_torque = 1'b0;
		pos_dev = '0;
		go(16'h2100);
		cycles(3);
		chk_val("press stop", 32'h0, speed_cmd_r);
		chk_bit("stop quiet", 1'b0, status_r.ovl_alarm);
		// next run after a press relaunches at launch speed with pressing clear
		go(16'h1000);
		wait_for('0, 1'b1, 8);
		chk_val("relaunch", launch_speed, speed_cmd_r);
		chk_bit("no press after", 1'b0, status_r.pressing);
		$display("test alarms done");
		stop_test();
	end
endmodule
